// File: hw/urs_pkg.sv
// Purpose: Shared constants and types for the serial transceiver
// Assumes: 32-bit register port, byte offsets
// Notes:   Field positions follow the control and status words
package urs_pkg;
  localparam logic [11:0] OFS_DATA  = 12'h000;
  localparam logic [11:0] OFS_RSR   = 12'h004;
  localparam logic [11:0] OFS_FLAG  = 12'h018;
  localparam logic [11:0] OFS_LPDIV = 12'h020;
  localparam logic [11:0] OFS_IBRD  = 12'h024;
  localparam logic [11:0] OFS_FBRD  = 12'h028;
  localparam logic [11:0] OFS_LCRH  = 12'h02C;
  localparam logic [11:0] OFS_CTL   = 12'h030;
  localparam logic [11:0] OFS_IFLS  = 12'h034;
  localparam logic [11:0] OFS_MASK  = 12'h038;
  localparam logic [11:0] OFS_RIS   = 12'h03C;
  localparam logic [11:0] OFS_MIS   = 12'h040;
  localparam logic [11:0] OFS_ICR   = 12'h044;
  // Control word bits
  localparam int CTL_EN   = 0;
  localparam int CTL_SIR  = 1;
  localparam int CTL_SLP  = 2;
  localparam int CTL_LOOP = 7;
  localparam int CTL_TXON = 8;
  localparam int CTL_RXON = 9;
  localparam logic [9:0] CTL_RST  = 10'h300;
  localparam logic [5:0] IFLS_RST = 6'h12;
  // Interrupt status bits
  localparam int IRQ_RX = 4;
  localparam int IRQ_TX = 5;
  localparam int IRQ_RT = 6;
  localparam int IRQ_FE = 7;
  localparam int IRQ_PE = 8;
  localparam int IRQ_BE = 9;
  localparam int IRQ_OE = 10;
  localparam int FLAG_BUSY = 3;
  localparam logic [8:0] RT_TICKS   = 9'h1FF;
  localparam logic [3:0] START_MID  = 4'h7;
  localparam logic [3:0] BIT_LAST   = 4'hF;
  localparam logic [3:0] SIR_PULSE  = 4'h3;
  localparam logic [4:0] SIR_HOLD   = 5'h10;
  localparam logic [1:0] LP_PULSE   = 2'h3;

  typedef struct packed {
    logic       sps;
    logic [1:0] wlen;
    logic       fifo_on;
    logic       stp2;
    logic       eps;
    logic       pen;
    logic       brk;
  } urs_lcr_t;

  typedef struct packed {
    logic [15:0] div_int;
    logic [5:0]  div_frac;
    urs_lcr_t    lcr;
  } urs_line_cfg_t;

  typedef struct packed {
    logic       oe;
    logic       be;
    logic       pe;
    logic       fe;
    logic [7:0] data;
  } urs_rx_word_t;
endpackage : urs_pkg

// File: hw/urs_uart.sv
// Purpose: Serial transceiver with fractional baud, FIFOs and IR coding
// Assumes: One clock, registers on a plain strobe port
// Notes:   Line settings take effect only on a line-control write
// Notes on behaviour
// [RULE1] Both directions enabled; finish character when disabled
// [RULE2] Software disables before reprogramming control
// [RULE3] Frame: start, data LSB first, parity, stops
// [RULE4] Divisor is 16-bit integer plus 6-bit fraction
// [RULE5] Divisor makes x16 tick; sixteen ticks per bit
// [RULE6] Divisors and line control latch on line-control write
// [RULE7] Send frames back to back until FIFO empty
// [RULE8] Busy until FIFO empty and stop bits sent
// [RULE9] Start bit confirmed low at eighth tick
// [RULE10] Data sampled every sixteenth tick, then parity
// [RULE11] Framing error on low stop; push with flags
// [RULE12] IR zero is 3/16 high pulse
// [RULE13] Low-power IR pulse is three low-power ticks
// [RULE14] Software handles IR half-duplex turnaround delay
// [RULE15] Sixteen-entry FIFOs; 8-bit push, 12-bit pop
// [RULE16] One-deep until FIFO enable; status flags reported
// [RULE17] Selectable thresholds per FIFO, half by default
// [RULE18] Seven sources ORed onto one request
// [RULE19] Mask gates sources; raw and masked readable
// [RULE20] Writing one to clear register clears source
// [RULE21] Receive timeout after 32 idle bit periods
// [RULE22] Loopback routes serial output to input
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module urs_uart
  import urs_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        serial_in_i,
  output logic             serial_out_o,
  output logic             irq_o
);
  localparam int PW = $clog2(DEPTH);

  function automatic logic [PW:0] level_count(input logic [2:0] sel);
    logic [PW+1:0] d;
    d = (PW+2)'(DEPTH);
    unique case (sel)
      3'h0:    level_count = d[PW+1:1] >> 2;
      3'h1:    level_count = d[PW+1:1] >> 1;
      3'h3:    level_count = d[PW:0] - (d[PW+1:1] >> 1);
      3'h4:    level_count = d[PW:0] - (d[PW+1:1] >> 2);
      default: level_count = d[PW+1:1];
    endcase
  endfunction : level_count

  function automatic logic parity_of(input logic [7:0] d, input urs_lcr_t l);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - l.wlen));
    if (l.sps) parity_of = ~l.eps;
    else parity_of = l.eps ? ^m : ~^m;
  endfunction : parity_of

  ////////////////////////////////////////////////////////////////////////
  logic [9:0]    ctl_q;
  logic [15:0]   ibrd_q;
  logic [5:0]    fbrd_q;
  urs_lcr_t      lcrh_q;
  urs_line_cfg_t cfg_q;
  logic [5:0]    ifls_q;
  logic [10:4]   msk_q;
  logic [10:4]   ris_q;
  logic [3:0]    rsr_q;
  logic [7:0]    lpdiv_q;
  logic          wr_data, rd_data, wr_icr, en;

  assign wr_data = wr_i && addr_i == OFS_DATA;
  assign rd_data = rd_i && addr_i == OFS_DATA;
  assign wr_icr  = wr_i && addr_i == OFS_ICR;
  assign en      = ctl_q[CTL_EN];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctl_q   <= CTL_RST; // RULE1
      ibrd_q  <= '0;
      fbrd_q  <= '0;
      lcrh_q  <= '0;
      cfg_q   <= '0;
      ifls_q  <= IFLS_RST; // RULE17
      msk_q   <= '0;
      lpdiv_q <= '0;
    end else if (wr_i) begin
      unique case (addr_i)
        OFS_CTL:   ctl_q   <= wdata_i[9:0];
        OFS_IBRD:  ibrd_q  <= wdata_i[15:0]; // RULE4
        OFS_FBRD:  fbrd_q  <= wdata_i[5:0];
        OFS_LPDIV: lpdiv_q <= wdata_i[7:0];
        OFS_IFLS:  ifls_q  <= wdata_i[5:0];
        OFS_MASK:  msk_q   <= wdata_i[10:4];
        OFS_LCRH:  begin
          lcrh_q <= urs_lcr_t'(wdata_i[7:0]);
          cfg_q  <= {ibrd_q, fbrd_q, wdata_i[7:0]}; // RULE6
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fractional x16 tick and low-power tick
  logic [15:0] bcnt_q;
  logic [5:0]  facc_q;
  logic [6:0]  fsum;
  logic [16:0] bper;
  logic        tick;
  logic [7:0]  lpcnt_q;
  logic        lptick;

  assign fsum = {1'b0, facc_q} + {1'b0, cfg_q.div_frac};
  assign bper = {1'b0, cfg_q.div_int} + {16'h0000, fsum[6]};
  assign tick = cfg_q.div_int != '0 && ({1'b0, bcnt_q} + 17'h00001) >= bper; // RULE5

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bcnt_q <= '0;
      facc_q <= '0;
    end else if (tick) begin
      bcnt_q <= '0;
      facc_q <= fsum[5:0]; // RULE4
    end else begin
      bcnt_q <= bcnt_q + 16'h0001;
    end
  end

  assign lptick = lpdiv_q != '0 && (lpcnt_q + 8'h01) >= lpdiv_q;

  always_ff @(posedge clock_i) begin
    if (rst_i || lptick) lpcnt_q <= '0;
    else lpcnt_q <= lpcnt_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // FIFOs; depth falls to one until enabled
  logic [7:0]   txm [DEPTH];
  urs_rx_word_t rxm [DEPTH];
  logic [PW-1:0] txw_q, txr_q, rxw_q, rxr_q;
  logic [PW:0]  txc_q, rxc_q, depth_eff;
  logic         tx_pop, rx_push, rx_pop, tx_full, rx_full, tx_push;
  urs_rx_word_t rx_word;

  assign depth_eff = cfg_q.lcr.fifo_on ? (PW+1)'(DEPTH) : (PW+1)'(1); // RULE16
  assign tx_full   = txc_q >= depth_eff;
  assign rx_full   = rxc_q >= depth_eff;
  assign tx_push   = wr_data && !tx_full;
  assign rx_pop    = rd_data && rxc_q != '0;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      txw_q <= '0;
      txr_q <= '0;
      txc_q <= '0;
    end else begin
      if (tx_push) begin
        txm[txw_q] <= wdata_i[7:0]; // RULE15
        txw_q      <= txw_q + 1'b1;
      end
      if (tx_pop) txr_q <= txr_q + 1'b1;
      txc_q <= txc_q + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rxw_q <= '0;
      rxr_q <= '0;
      rxc_q <= '0;
    end else begin
      if (rx_push && !rx_full) begin
        rxm[rxw_q] <= rx_word; // RULE11
        rxw_q      <= rxw_q + 1'b1;
      end
      if (rx_pop) rxr_q <= rxr_q + 1'b1;
      rxc_q <= rxc_q + (PW+1)'(rx_push && !rx_full) - (PW+1)'(rx_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} urs_tx_st_t;
  urs_tx_st_t tst_q;
  logic [3:0] tph_q;
  logic [2:0] tbit_q;
  logic [7:0] tsh_q;
  logic       tpar_q, tline, bit_end, busy;

  assign tx_pop  = tst_q == TX_IDLE && txc_q != '0 && en && ctl_q[CTL_TXON]; // RULE7
  assign bit_end = tick && tph_q == BIT_LAST;
  assign busy    = txc_q != '0 || tst_q != TX_IDLE; // RULE8

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tst_q  <= TX_IDLE;
      tph_q  <= '0;
      tbit_q <= '0;
      tsh_q  <= '0;
      tpar_q <= 1'b0;
    end else begin
      if (tick) tph_q <= tph_q + 4'h1;
      unique case (tst_q)
        TX_IDLE: if (tx_pop) begin
          tsh_q  <= txm[txr_q];
          tpar_q <= parity_of(txm[txr_q], cfg_q.lcr);
          tph_q  <= '0;
          tst_q  <= TX_START; // RULE3
        end
        TX_START: if (bit_end) begin
          tbit_q <= '0;
          tst_q  <= TX_DATA;
        end
        TX_DATA: if (bit_end) begin
          tsh_q  <= tsh_q >> 1; // RULE3
          tbit_q <= tbit_q + 3'h1;
          if (tbit_q == {1'b1, cfg_q.lcr.wlen}) begin
            tbit_q <= '0;
            tst_q  <= cfg_q.lcr.pen ? TX_PAR : TX_STOP;
          end
        end
        TX_PAR: if (bit_end) tst_q <= TX_STOP;
        TX_STOP: if (bit_end) begin
          tbit_q <= tbit_q + 3'h1;
          // Ends regardless of enable, so a disable never cuts a frame
          if (tbit_q[0] || !cfg_q.lcr.stp2) tst_q <= TX_IDLE; // RULE1
        end
      endcase
    end
  end

  always_comb begin
    unique case (tst_q)
      TX_START: tline = 1'b0;
      TX_DATA:  tline = tsh_q[0];
      TX_PAR:   tline = tpar_q;
      default:  tline = 1'b1;
    endcase
    if (cfg_q.lcr.brk) tline = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // IR encoder and output register
  logic [1:0] lpp_q;
  logic       out_q, sir_nrm, sir_q;

  assign sir_nrm = !tline && tst_q != TX_IDLE && tph_q < SIR_PULSE; // RULE12

  always_ff @(posedge clock_i) begin
    if (rst_i) lpp_q <= '0;
    else if (tick && tph_q == '0 && !tline && tst_q != TX_IDLE) lpp_q <= LP_PULSE; // RULE13
    else if (lptick && lpp_q != '0) lpp_q <= lpp_q - 2'h1;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) out_q <= 1'b1;
    else if (ctl_q[CTL_SIR]) out_q <= ctl_q[CTL_SLP] ? lpp_q != '0 : sir_nrm;
    else out_q <= tline;
  end
  assign serial_out_o = out_q;

  // Mode of the bit now on the pin, so a mode switch is no loopback glitch
  always_ff @(posedge clock_i) begin
    if (rst_i) sir_q <= 1'b0;
    else sir_q <= ctl_q[CTL_SIR];
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser, loopback and IR decoder
  logic       s1_q, s2_q, s3_q, pin_q, raw, rxd;
  logic [4:0] hold_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s1_q  <= 1'b1;
      s2_q  <= 1'b1;
      s3_q  <= 1'b1;
      pin_q <= 1'b1;
    end else begin
      s1_q <= serial_in_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) pin_q <= s3_q;
    end
  end

  // IR pulses are active high on the wire, so loopback inverts them
  assign raw = ctl_q[CTL_LOOP] ? (sir_q ? !out_q : out_q) : pin_q; // RULE22

  always_ff @(posedge clock_i) begin
    if (rst_i) hold_q <= '0;
    else if (!raw) hold_q <= SIR_HOLD;
    else if (tick && hold_q != '0) hold_q <= hold_q - 5'h01;
  end
  assign rxd = ctl_q[CTL_SIR] ? hold_q == '0 : raw; // RULE12

  ////////////////////////////////////////////////////////////////////////
  // Receiver
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} urs_rx_st_t;
  urs_rx_st_t rst_q;
  logic [3:0] rph_q;
  logic [2:0] rbit_q;
  logic [7:0] rsh_q, rdat;
  logic       rpar_q, oep_q, rsamp;

  assign rsamp = tick && rph_q == BIT_LAST;
  assign rdat  = rsh_q >> (2'h3 - cfg_q.lcr.wlen);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rst_q  <= RX_IDLE;
      rph_q  <= '0;
      rbit_q <= '0;
      rsh_q  <= '0;
      rpar_q <= 1'b0;
    end else begin
      if (tick) rph_q <= rph_q + 4'h1;
      unique case (rst_q)
        RX_IDLE: if (!rxd && en && ctl_q[CTL_RXON]) begin
          rph_q <= '0;
          rst_q <= RX_START; // RULE9
        end
        RX_START: if (tick && rph_q == START_MID) begin
          rph_q  <= '0;
          rbit_q <= '0;
          rst_q  <= rxd ? RX_IDLE : RX_DATA; // RULE9
        end
        RX_DATA: if (rsamp) begin
          rsh_q  <= {rxd, rsh_q[7:1]}; // RULE10
          rbit_q <= rbit_q + 3'h1;
          if (rbit_q == {1'b1, cfg_q.lcr.wlen}) rst_q <= cfg_q.lcr.pen ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rsamp) begin
          rpar_q <= rxd;
          rst_q  <= RX_STOP;
        end
        RX_STOP: if (rsamp) rst_q <= RX_IDLE;
        default: rst_q <= RX_IDLE;
      endcase
    end
  end

  assign rx_push      = rst_q == RX_STOP && rsamp;
  assign rx_word.data = rdat;
  assign rx_word.fe   = !rxd; // RULE11
  assign rx_word.pe   = cfg_q.lcr.pen && rpar_q != parity_of(rdat, cfg_q.lcr); // RULE10
  assign rx_word.be   = !rxd && rdat == '0 && !(cfg_q.lcr.pen && rpar_q);
  assign rx_word.oe   = oep_q;

  // Overrun marks the next stored word since the lost one has no slot
  always_ff @(posedge clock_i) begin
    if (rst_i) oep_q <= 1'b0;
    else if (rx_push) oep_q <= rx_full;
  end

  ////////////////////////////////////////////////////////////////////////
  // Timeout, interrupt status and receive status
  logic [8:0]  rt_q;
  logic        txl, rxl, txl_q, rxl_q;
  logic [10:4] set, clr;

  always_ff @(posedge clock_i) begin
    if (rst_i || rx_push || rxc_q == '0) rt_q <= '0;
    else if (tick && rt_q != RT_TICKS) rt_q <= rt_q + 9'h001; // RULE21
  end

  assign txl = txc_q <= level_count(ifls_q[2:0]); // RULE17
  assign rxl = rxc_q >= level_count(ifls_q[5:3]);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // Empty FIFO is below its level; avoids a false edge after reset
      txl_q <= 1'b1;
      rxl_q <= 1'b0;
    end else begin
      txl_q <= txl;
      rxl_q <= rxl;
    end
  end

  always_comb begin
    set         = '0;
    set[IRQ_TX] = txl && !txl_q;
    set[IRQ_RX] = rxl && !rxl_q;
    set[IRQ_RT] = tick && rt_q == RT_TICKS - 9'h001; // RULE21
    set[IRQ_FE] = rx_push && rx_word.fe; // RULE18
    set[IRQ_PE] = rx_push && rx_word.pe;
    set[IRQ_BE] = rx_push && rx_word.be;
    set[IRQ_OE] = rx_push && rx_full;
    clr         = wr_icr ? wdata_i[10:4] : '0; // RULE20
    clr[IRQ_RT] = clr[IRQ_RT] || (rx_pop && rxc_q == (PW+1)'(1)); // RULE21
  end

  // A new event in the clearing cycle survives
  always_ff @(posedge clock_i) begin
    if (rst_i) ris_q <= '0;
    else ris_q <= (ris_q & ~clr) | set; // RULE20
  end

  assign irq_o = |(ris_q & msk_q); // RULE19

  always_ff @(posedge clock_i) begin
    if (rst_i) rsr_q <= '0;
    else begin
      if (wr_i && addr_i == OFS_RSR) rsr_q <= '0;
      else if (rx_pop) rsr_q <= {rsr_q[3] | rxm[rxr_q].oe, rxm[rxr_q].be, rxm[rxr_q].pe, rxm[rxr_q].fe};
      // Overrun in the clearing cycle survives
      if (rx_push && rx_full) rsr_q[3] <= 1'b1; // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge clock_i) begin
    if (rst_i) rdata_o <= '0;
    else if (rd_i) begin
      unique case (addr_i)
        OFS_DATA:  rdata_o <= {20'h00000, rxm[rxr_q]}; // RULE15
        OFS_RSR:   rdata_o <= {28'h0000000, rsr_q};
        OFS_FLAG:  rdata_o <= {24'h000000, txc_q == '0, rx_full, tx_full, rxc_q == '0, busy, 3'h0};
        OFS_LPDIV: rdata_o <= {24'h000000, lpdiv_q};
        OFS_IBRD:  rdata_o <= {16'h0000, ibrd_q};
        OFS_FBRD:  rdata_o <= {26'h0, fbrd_q};
        OFS_LCRH:  rdata_o <= {24'h000000, lcrh_q};
        OFS_CTL:   rdata_o <= {22'h0, ctl_q};
        OFS_IFLS:  rdata_o <= {26'h0, ifls_q};
        OFS_MASK:  rdata_o <= {21'h0, msk_q, 4'h0};
        OFS_RIS:   rdata_o <= {21'h0, ris_q, 4'h0}; // RULE19
        OFS_MIS:   rdata_o <= {21'h0, ris_q & msk_q, 4'h0};
        default:   rdata_o <= '0;
      endcase
    end
  end
endmodule : urs_uart

// File: tb/urs_uart_asserts.sv
// Purpose: Port checks for the serial transceiver
// Assumes: Shadow copies of the written control words
// Notes:   Bit widths assume a latched divisor of one
`timescale 1ns/1ps
module urs_uart_asserts
  import urs_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        serial_in_i,
  input wire logic        serial_out_o,
  input wire logic        irq_o
);
  logic [9:0]  ctl_q;
  logic [5:0]  ifls_q;
  logic [6:0]  mask_q;
  logic [15:0] ibrd_q;
  logic [5:0]  fbrd_q;
  logic        fast_q;
  logic        mapped;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  assign mapped = addr_i inside {OFS_DATA, OFS_RSR, OFS_FLAG, OFS_LPDIV, OFS_IBRD, OFS_FBRD,
                                 OFS_LCRH, OFS_CTL, OFS_IFLS, OFS_MASK, OFS_RIS, OFS_MIS, OFS_ICR};
  // Divisor copies only matter once line control latches them
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctl_q  <= CTL_RST;
      ifls_q <= IFLS_RST;
      mask_q <= 7'h00;
      ibrd_q <= 16'h0000;
      fbrd_q <= 6'h00;
      fast_q <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        OFS_CTL:  ctl_q  <= wdata_i[9:0];
        OFS_IFLS: ifls_q <= wdata_i[5:0];
        OFS_MASK: mask_q <= wdata_i[10:4];
        OFS_IBRD: ibrd_q <= wdata_i[15:0];
        OFS_FBRD: fbrd_q <= wdata_i[5:0];
        OFS_LCRH: fast_q <= (ibrd_q == 16'h0001) && (fbrd_q == 6'h00);
        default:  ;
      endcase
    end
  end
  sequence low_bit_s;
    (!serial_out_o)[*8] ##1 (!serial_out_o)[*8];
  endsequence
  sequence ir_pulse_s;
    serial_out_o[*3] ##1 !serial_out_o;
  endsequence
  reset_idle_a: assert property ($fell(rst_i) |-> serial_out_o && !irq_o && (rdata_o == 32'h00000000))
    else $error("outputs not idle after reset");
  ctl_read_a: assert property (rd_i && addr_i == OFS_CTL |=> (rdata_o & 32'h00000387) == {22'h0, ctl_q & 10'h387})
    else $error("control readback wrong");
  ifls_read_a: assert property (rd_i && addr_i == OFS_IFLS |=> rdata_o[5:0] == ifls_q)
    else $error("level select readback wrong");
  mask_read_a: assert property (rd_i && addr_i == OFS_MASK |=> rdata_o[10:4] == mask_q)
    else $error("mask readback wrong");
  mis_irq_a: assert property (rd_i && addr_i == OFS_MIS |=> (|rdata_o[10:4]) == $past(irq_o))
    else $error("masked status disagrees with request");
  mask_gate_a: assert property (mask_q == 7'h00 |-> !irq_o)
    else $error("request with all sources masked");
  unmapped_zero_a: assert property (rd_i && !mapped |=> rdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  data_width_a: assert property (rd_i && addr_i == OFS_DATA |=> rdata_o[31:12] == 20'h00000)
    else $error("data word too wide");
  bit_time_a: assert property ($fell(serial_out_o) && fast_q && !ctl_q[CTL_SIR] |-> low_bit_s)
    else $error("low bit shorter than sixteen ticks");
  ir_pulse_a: assert property ($rose(serial_out_o) && fast_q && ctl_q[CTL_SIR] && !ctl_q[CTL_SLP] |-> ir_pulse_s)
    else $error("ir pulse not three ticks");
endmodule : urs_uart_asserts
bind urs_uart urs_uart_asserts u_asserts (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o), .irq_o(irq_o));

// File: tb/urs_remote_model.sv
// Purpose: Remote serial device on the line side
// Assumes: Receives 8N1 only; bit time in clocks
// Notes:   Line idles high as if pulled up
`timescale 1ns/1ps
module urs_remote_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic       clock_i,
  input  wire logic       line_i,
  output logic            line_o,
  output logic [7:0]      rx_byte_o,
  output int              rx_count_o
);
  initial line_o = 1'b1;
  // Parity and stop may be corrupted on purpose
  task automatic send(input logic [7:0] d, input logic par_en, input logic par_bad, input logic stop_v);
    logic [10:0] bits;
    bits = {stop_v, (^d) ^ par_bad, d, 1'b0};
    if (!par_en) bits[9] = stop_v;
    for (int i = 0; i < (par_en ? 11 : 10); i++) begin
      @(posedge clock_i);
      line_o <= bits[i];
      repeat (BIT_CLKS - 1) @(posedge clock_i);
    end
    @(posedge clock_i);
    line_o <= 1'b1;
  endtask : send
  task automatic glitch(input int len);
    @(posedge clock_i);
    line_o <= 1'b0;
    repeat (len) @(posedge clock_i);
    line_o <= 1'b1;
  endtask : glitch
  initial begin
    logic [7:0] b;
    rx_byte_o  = 8'h00;
    rx_count_o = 0;
    forever begin
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(posedge clock_i);
      if (!line_i) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS) @(posedge clock_i);
          b[i] = line_i;
        end
        repeat (BIT_CLKS) @(posedge clock_i);
        if (line_i) begin
          rx_byte_o  <= b;
          rx_count_o <= rx_count_o + 1;
        end
      end
    end
  end
endmodule : urs_remote_model

// File: tb/tb_top.sv
// Purpose: Register-level tests of the serial transceiver
// Assumes: Divisor one, so a bit is sixteen clocks
// Notes:   Waits are bounded and end the run when spent
`timescale 1ns/1ps
module tb_top
  import urs_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic [11:0] addr_i  = 12'h000;
  logic [31:0] wdata_i = 32'h00000000;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [31:0] rdata_o;
  logic        serial_in_i;
  logic        serial_out_o;
  logic        irq_o;
  logic [7:0]  rx_byte;
  int          rx_count;
  int          errors  = 0;
  int          n_tests = 0;
  logic [31:0] rv;
  initial forever #10 clock_i = ~clock_i;
  urs_uart #(.DEPTH(16)) dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
    .irq_o(irq_o));
  urs_remote_model #(.BIT_CLKS(16)) u_remote (.clock_i(clock_i), .line_i(serial_out_o), .line_o(serial_in_i),
    .rx_byte_o(rx_byte), .rx_count_o(rx_count));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
    check(rv & m, exp);
  endtask : rd_chk
  task automatic wait_flag(input int b, input logic v);
    for (int i = 0; i < 600; i++) begin
      rd_chk(OFS_FLAG, 32'h00000000, 32'h00000000);
      if (rv[b] === v) return;
    end
    errors++;
    conclude();
  endtask : wait_flag
  task automatic wait_tx(input int n, input logic [7:0] exp);
    for (int i = 0; i < 400 && rx_count < n; i++) @(posedge clock_i);
    if (rx_count < n) begin
      errors++;
      conclude();
    end else begin
      check({24'h0, rx_byte}, {24'h0, exp});
    end
  endtask : wait_tx
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    rd_chk(OFS_CTL, 32'hFFFFFFFF, 32'h00000300);
    rd_chk(OFS_IFLS, 32'hFFFFFFFF, 32'h00000012);
    rd_chk(OFS_FLAG, 32'h000000F8, 32'h00000090);
    reg_wr(12'h008, 32'hFFFFFFFF);
    rd_chk(12'h008, 32'hFFFFFFFF, 32'h00000000);
    reg_wr(OFS_IFLS, 32'h00000024);
    rd_chk(OFS_IFLS, 32'h0000003F, 32'h00000024);
    reg_wr(OFS_IBRD, 32'hFFFFFFFF);
    rd_chk(OFS_IBRD, 32'hFFFFFFFF, 32'h0000FFFF);
    reg_wr(OFS_FBRD, 32'hFFFFFFFF);
    rd_chk(OFS_FBRD, 32'hFFFFFFFF, 32'h0000003F);
    reg_wr(OFS_IBRD, 32'h00000001);
    reg_wr(OFS_FBRD, 32'h00000000);
    reg_wr(OFS_LCRH, 32'h00000070);
    reg_wr(OFS_CTL, 32'h00000301);
    reg_wr(OFS_DATA, 32'h000000A5);
    rd_chk(OFS_FLAG, 32'h00000008, 32'h00000008);
    wait_tx(1, 8'hA5);
    rd_chk(OFS_FLAG, 32'h00000008, 32'h00000008);
    wait_flag(FLAG_BUSY, 1'b0);
    reg_wr(OFS_DATA, 32'h00000001);
    reg_wr(OFS_DATA, 32'h00000080);
    reg_wr(OFS_DATA, 32'h0000007E);
    wait_tx(2, 8'h01);
    wait_tx(3, 8'h80);
    wait_tx(4, 8'h7E);
    reg_wr(OFS_DATA, 32'h000000C3);
    repeat (40) @(posedge clock_i);
    reg_wr(OFS_CTL, 32'h00000300);
    wait_tx(5, 8'hC3);
    wait_flag(FLAG_BUSY, 1'b0);
    reg_wr(OFS_IBRD, 32'h00000002);
    reg_wr(OFS_CTL, 32'h00000301);
    u_remote.send(8'h3C, 1'b0, 1'b0, 1'b1);
    wait_flag(4, 1'b0);
    rd_chk(OFS_DATA, 32'hFFFFFFFF, 32'h0000003C);
    rd_chk(OFS_FLAG, 32'h00000010, 32'h00000010);
    u_remote.glitch(4);
    repeat (200) @(posedge clock_i);
    rd_chk(OFS_FLAG, 32'h00000010, 32'h00000010);
    reg_wr(OFS_CTL, 32'h00000300);
    reg_wr(OFS_IBRD, 32'h00000001);
    reg_wr(OFS_LCRH, 32'h00000076);
    reg_wr(OFS_CTL, 32'h00000301);
    u_remote.send(8'h5A, 1'b1, 1'b1, 1'b1);
    wait_flag(4, 1'b0);
    rd_chk(OFS_DATA, 32'h00000FFF, 32'h0000025A);
    u_remote.send(8'h66, 1'b1, 1'b0, 1'b0);
    repeat (600) @(posedge clock_i);
    rd_chk(OFS_RIS, 32'h000000C0, 32'h000000C0);
    reg_wr(OFS_MASK, 32'h00000000);
    check({31'h0, irq_o}, 32'h00000000);
    reg_wr(OFS_MASK, 32'h00000080);
    check({31'h0, irq_o}, 32'h00000001);
    rd_chk(OFS_MASK, 32'h000007F0, 32'h00000080);
    rd_chk(OFS_MIS, 32'hFFFFFFFF, 32'h00000080);
    reg_wr(OFS_ICR, 32'h00000080);
    check({31'h0, irq_o}, 32'h00000000);
    rd_chk(OFS_RIS, 32'h00000080, 32'h00000000);
    rd_chk(OFS_DATA, 32'h00000FFF, 32'h00000166);
    rd_chk(OFS_RIS, 32'h00000040, 32'h00000000);
    reg_wr(OFS_CTL, 32'h00000300);
    reg_wr(OFS_CTL, 32'h00000381);
    reg_wr(OFS_DATA, 32'h000000E7);
    wait_flag(4, 1'b0);
    rd_chk(OFS_DATA, 32'h00000FFF, 32'h000000E7);
    reg_wr(OFS_CTL, 32'h00000300);
    reg_wr(OFS_CTL, 32'h00000383);
    reg_wr(OFS_DATA, 32'h00000096);
    wait_flag(4, 1'b0);
    rd_chk(OFS_DATA, 32'h00000FFF, 32'h00000096);
    conclude();
  end
endmodule : tb_top
